// file: verilog/divide_stage_pkg.sv
// Shared constants, carrier types and rank pick function for the radix-8 remainder stage.
package divide_stage_pkg;

  // Data path geometry.
  localparam int DIGIT_W  = 3;
  localparam int GROUPS   = 16;
  localparam int WORD_W   = 48;
  localparam int REM_W    = 51;

  // Iteration period numbers as counted by the stage.
  localparam logic [4:0] PERIOD_IDLE   = 5'h00;
  localparam logic [4:0] PERIOD_SECOND = 5'h02;
  localparam logic [4:0] PERIOD_LAST   = 5'h11;

  // Low digit patterns: round digits alternate 2 and 5, plain divide enters zero.
  localparam logic [2:0] ROUND_EVEN = 3'h2;
  localparam logic [2:0] ROUND_ODD  = 3'h5;
  localparam logic [2:0] LOW_ZERO   = 3'h0;

  // No borrow can enter the lowest group, so group one sees a constant zero.
  localparam logic       GROUP0_BORROW = 1'b0;

  // Values after reset.
  localparam logic [50:0] REM_RESET   = 51'h0;
  localparam logic [2:0]  DIGIT_RESET = 3'h0;
  localparam logic        FLAG_RESET  = 1'b0;

  // Iteration phase, Gray coded along idle, second, middle, last.
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_SECOND = 2'b01,
    PH_ITER   = 2'b11,
    PH_LAST   = 2'b10
  } phase_t;

  // Divisor multiples of ranks one to seven, low 48 bits used by the partial network.
  typedef struct packed {
    logic [7:1][47:0] value;
  } multiples_t;

  // Results of the trial network: one flag per rank and group borrows for groups 2 to 16.
  typedef struct packed {
    logic [7:1]       end_around_borrow;
    logic [7:1][16:2] group_borrow;
  } trial_result_t;

  // Highest rank whose flag is clear; rank zero never has a flag.
  function automatic logic [2:0] pick_rank(input logic [7:1] flags);
    logic [2:0] rank;
    rank = 3'h0;
    for (int r = 1; r <= 7; r++) begin
      if (!flags[r]) begin
        rank = 3'(r);
      end
    end
    return rank;
  endfunction : pick_rank

endpackage : divide_stage_pkg

// file: verilog/partial_digit_slice.sv
// One octal digit of the partial subtraction network.
`timescale 1ns/1ps
`default_nettype none
module partial_digit_slice
  import divide_stage_pkg::*;
(
  input  wire logic [2:0]      rem_digit,
  input  wire logic [7:1][2:0] mult_digit,
  output logic      [7:1][2:0] enable
);

  // Complemented remainder digit plus each multiple digit, modulo eight.
  always_comb begin
    for (int r = 1; r <= 7; r++) begin
      enable[r] = 3'(~rem_digit + mult_digit[r]); // [RL2]
    end
  end

endmodule : partial_digit_slice
`default_nettype wire

// file: verilog/final_digit_slice.sv
// One octal digit of the final subtraction network.
`timescale 1ns/1ps
`default_nettype none
module final_digit_slice
  import divide_stage_pkg::*;
(
  input  wire logic [7:1]      flags,
  input  wire logic [7:1]      borrow,
  input  wire logic [7:0][2:0] enable,
  output logic      [2:0]      result
);

  logic [2:0] rank;
  logic       rank_borrow;
  logic [7:0] borrow_ext;

  // Each slice picks its rank locally, which keeps the flag fan-out flat.
  always_comb begin
    rank        = pick_rank(flags); // [RL12] [RL15]
    // Rank zero never borrows; a zero below the borrows keeps the index in range.
    borrow_ext  = {borrow, 1'b0};
    rank_borrow = borrow_ext[rank];
    result      = ~3'(enable[rank] + {2'b00, rank_borrow}); // [RL13]
  end

endmodule : final_digit_slice
`default_nettype wire

// file: verilog/radix8_divide_remainder_stage.sv
// Remainder update stage of a radix-8 divider: partial and final subtraction.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RL1] Remainder bits 0-47 form sixteen octal groups, each with its own slice.
// [RL2] Each slice adds complemented remainder digit to all seven multiple digits.
// [RL3] Partial outputs move up one octal digit before the final stage.
// [RL4] Shifted remainder: top three bits become 48-50, bits 0-44 become 3-47.
// [RL5] Rank-zero bits 48-50 pass only in periods two to seventeen.
// [RL6] Circulate select picks shifted remainder or dividend for rank-zero bits 3-47.
// [RL7] First period feeds the dividend, later periods the remainder, both complemented.
// [RL8] All rank-zero source bits are inverted to form rank-zero enables.
// [RL9] Round divide enters 2 and 5 alternately into bits 0-2 from period two.
// [RL10] Round flag captured at the start, forwarded to the low digit from period two.
// [RL11] Low group loads dividend first, then zero or round pattern every period.
// [RL12] Final stage selects the highest rank whose borrow flag is clear.
// [RL13] Selected rank digit plus its group borrow, inverted, enters the remainder.
// [RL14] Selected rank is registered as the quotient digit and forwarded.
// [RL15] Each final slice gets seven flags, seven borrows and eight enable digits.
// [RL16] Group one borrows come from the low group; others from the trial network.
// [RL17] Remainder bits 0-47 feed back to the partial network every period.
// [RL18] A set flag means remainder below that multiple; clear means not below.
// [RL19] Trial network forces flags in the first period so rank zero loads dividend.
// [RL20] Trial network limits the first quotient digit to ranks zero to two.
// [RL21] Registers update on each rising edge, one digit per active period.
// [RL22] Reset clears remainder, quotient digit and round flag; stage then idles.
module radix8_divide_remainder_stage
  import divide_stage_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          first_iteration_period,
  input  wire logic          round_request,
  input  wire logic [47:0]   dividend,
  input  wire multiples_t    multiples,
  input  wire trial_result_t trial,
  output logic      [50:0]   remainder,
  output logic      [2:0]    quotient_digit,
  output logic               digit_valid,
  output logic               round_request_flag,
  output logic               second_iteration_period,
  output logic               last_iteration_period,
  output logic               busy
);

  phase_t                  phase;
  logic [4:0]              period_count;
  logic                    in_iter;
  logic                    active;
  logic [2:0]              low_digit;
  logic [50:0]             rank0_source;
  logic [50:0]             rank0_enable;
  logic [15:0][7:1][2:0]   part_enable;
  logic [16:1][7:0][2:0]   final_enable;
  logic [16:1][7:1]        final_borrow;
  logic [50:0]             next_remainder;
  logic [2:0]              next_digit;

  // Period decode; a first period always restarts the sequence.
  assign in_iter                 = (phase != PH_IDLE) && !first_iteration_period;
  assign active                  = first_iteration_period || in_iter;
  assign second_iteration_period = in_iter && (phase == PH_SECOND);
  assign last_iteration_period   = in_iter && (phase == PH_LAST);
  assign busy                    = active;

  // Phase machine, advanced by the period counter.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else if (first_iteration_period) begin
      phase <= PH_SECOND;
    end else begin
      case (phase)
        PH_SECOND: phase <= PH_ITER;
        PH_ITER:   phase <= (period_count == PERIOD_LAST - 5'h01) ? PH_LAST : PH_ITER;
        PH_LAST:   phase <= PH_IDLE;
        default:   phase <= PH_IDLE;
      endcase
    end
  end

  // Period counter holds the number of the current period while iterating.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      period_count <= PERIOD_IDLE;
    end else if (first_iteration_period) begin
      period_count <= PERIOD_SECOND;
    end else if (phase == PH_LAST || phase == PH_IDLE) begin
      period_count <= PERIOD_IDLE;
    end else begin
      period_count <= period_count + 5'h01;
    end
  end

  // Round flag is caught with the first period and held for the whole divide.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      round_request_flag <= FLAG_RESET; // [RL22]
    end else if (first_iteration_period) begin
      round_request_flag <= round_request; // [RL10]
    end
  end

  // Low digit: dividend first, then 2 on even and 5 on odd periods when rounding.
  always_comb begin
    if (first_iteration_period) begin
      low_digit = dividend[2:0]; // [RL11]
    end else if (in_iter && round_request_flag) begin
      low_digit = period_count[0] ? ROUND_ODD : ROUND_EVEN; // [RL9] [RL10]
    end else begin
      low_digit = LOW_ZERO; // [RL11]
    end
  end

  // Rank-zero source; the dividend only matters in the first period.
  always_comb begin
    rank0_source[2:0] = low_digit;
    if (first_iteration_period) begin
      rank0_source[47:3] = dividend[47:3]; // [RL6] [RL7]
    end else begin
      rank0_source[47:3] = remainder[44:0]; // [RL4] [RL6]
    end
    rank0_source[50:48] = in_iter ? remainder[47:45] : 3'h0; // [RL4] [RL5]
  end

  // Inverted source forms the rank-zero enables of every group.
  assign rank0_enable = ~rank0_source; // [RL8]

  // Sixteen partial slices on the remainder fed back from the register.
  for (genvar g = 0; g < GROUPS; g++) begin : g_partial
    logic [7:1][2:0] mult_digit;
    for (genvar r = 1; r <= 7; r++) begin : g_rank
      assign mult_digit[r] = multiples.value[r][DIGIT_W*g +: DIGIT_W];
    end
    partial_digit_slice u_partial (
      .rem_digit  (remainder[DIGIT_W*g +: DIGIT_W]), // [RL1] [RL17]
      .mult_digit (mult_digit),
      .enable     (part_enable[g])
    );
  end

  // Final slices for groups 1 to 16; partial group g lands in group g plus one.
  for (genvar j = 1; j <= GROUPS; j++) begin : g_final
    assign final_enable[j][0] = rank0_enable[DIGIT_W*j +: DIGIT_W];
    for (genvar r = 1; r <= 7; r++) begin : g_rank
      assign final_enable[j][r] = part_enable[j-1][r]; // [RL3]
      if (j == 1) begin : g_low
        assign final_borrow[j][r] = GROUP0_BORROW; // [RL16]
      end else begin : g_trial
        assign final_borrow[j][r] = trial.group_borrow[r][j]; // [RL16]
      end
    end
    final_digit_slice u_final (
      .flags  (trial.end_around_borrow), // [RL15] [RL18]
      .borrow (final_borrow[j]),
      .enable (final_enable[j]),
      .result (next_remainder[DIGIT_W*j +: DIGIT_W])
    );
  end

  // Group zero enables are the same for every rank and never borrow, so it loads its source.
  assign next_remainder[2:0] = rank0_source[2:0]; // [RL11]

  // The quotient digit is the same rank the final slices pick.
  assign next_digit = pick_rank(trial.end_around_borrow); // [RL12] [RL14]

  // Remainder register holds its value outside a divide so the bench can read it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remainder <= REM_RESET; // [RL22]
    end else if (active) begin
      remainder <= next_remainder; // [RL13] [RL21]
    end
  end

  // Quotient digit register and its valid strobe toward the shift register.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      quotient_digit <= DIGIT_RESET; // [RL22]
      digit_valid    <= 1'b0;
    end else begin
      digit_valid <= active;
      if (active) begin
        quotient_digit <= next_digit; // [RL14] [RL21]
      end
    end
  end

  // Checks on the registered results against their causes one period earlier.
  logic [7:1] all_flags;
  assign all_flags = 7'h7f;

  // Independent period count for the length checks, restarted by every first period.
  logic [4:0] check_count;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      check_count <= PERIOD_IDLE;
    end else if (first_iteration_period) begin
      check_count <= PERIOD_SECOND;
    end else if (check_count == PERIOD_LAST) begin
      check_count <= PERIOD_IDLE;
    end else if (check_count != PERIOD_IDLE) begin
      check_count <= check_count + 5'h01;
    end
  end

  property p_first_load;
    @(posedge ref_clk) disable iff (rst)
      (first_iteration_period && trial.end_around_borrow == all_flags)
      |=> (remainder == {3'h0, $past(dividend)});
  endproperty
  a_first_load: assert property (p_first_load) // [RL7] [RL19]
    else $error("first period did not load the dividend");

  property p_round_second;
    @(posedge ref_clk) disable iff (rst)
      (first_iteration_period && round_request) ##1 !first_iteration_period
      |=> (remainder[2:0] == ROUND_EVEN);
  endproperty
  a_round_second: assert property (p_round_second) // [RL9]
    else $error("round digit in second period is not 2");

  property p_round_alternate;
    @(posedge ref_clk) disable iff (rst)
      (in_iter && round_request_flag && !last_iteration_period) ##1 in_iter
      |=> (remainder[2:0] == ~$past(remainder[2:0]));
  endproperty
  a_round_alternate: assert property (p_round_alternate) // [RL9]
    else $error("round digits do not alternate");

  property p_plain_low;
    @(posedge ref_clk) disable iff (rst)
      (in_iter && !round_request_flag) |=> (remainder[2:0] == LOW_ZERO);
  endproperty
  a_plain_low: assert property (p_plain_low) // [RL11]
    else $error("plain divide low digit is not zero");

  property p_digit_pick;
    @(posedge ref_clk) disable iff (rst)
      active |=> digit_valid &&
        (({$past(trial.end_around_borrow), 1'b0} >> quotient_digit)
          == ((8'hff >> quotient_digit) & 8'hfe));
  endproperty
  a_digit_pick: assert property (p_digit_pick) // [RL12] [RL14]
    else $error("quotient digit is not the highest clear rank");

  property p_circulate;
    @(posedge ref_clk) disable iff (rst)
      (in_iter && trial.end_around_borrow == all_flags)
      |=> (remainder[50:3] == $past(remainder[47:0]));
  endproperty
  a_circulate: assert property (p_circulate) // [RL3] [RL4] [RL6]
    else $error("rank zero did not shift the remainder up one digit");

  property p_idle_hold;
    @(posedge ref_clk) disable iff (rst)
      !active |=> $stable(remainder) && !digit_valid;
  endproperty
  a_idle_hold: assert property (p_idle_hold) // [RL21]
    else $error("remainder changed outside a divide");

  // These checks lean on check_count, so a slip in the period counter cannot hide itself.
  property p_length;
    @(posedge ref_clk) disable iff (rst)
      !first_iteration_period
      |-> (last_iteration_period == (check_count == PERIOD_LAST));
  endproperty
  a_length: assert property (p_length) // [RL21]
    else $error("last period flag does not mark period seventeen");

  property p_end;
    @(posedge ref_clk) disable iff (rst)
      !first_iteration_period |-> (busy == (check_count != PERIOD_IDLE));
  endproperty
  a_end: assert property (p_end) // [RL21]
    else $error("stage busy outside periods one to seventeen");

  property p_round_parity;
    @(posedge ref_clk) disable iff (rst)
      (in_iter && round_request_flag)
      |=> (remainder[2:0] == ($past(check_count[0]) ? ROUND_ODD : ROUND_EVEN));
  endproperty
  a_round_parity: assert property (p_round_parity) // [RL9]
    else $error("round digit does not follow the period parity");

  property p_round_capture;
    @(posedge ref_clk) disable iff (rst)
      first_iteration_period |=> (round_request_flag == $past(round_request));
  endproperty
  a_round_capture: assert property (p_round_capture) // [RL10]
    else $error("round flag not caught with the first period");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (rst)
      !first_iteration_period |=> $stable(round_request_flag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) // [RL10]
    else $error("round flag changed during a divide");

  property p_low_first;
    @(posedge ref_clk) disable iff (rst)
      first_iteration_period |=> (remainder[2:0] == $past(dividend[2:0]));
  endproperty
  a_low_first: assert property (p_low_first) // [RL11]
    else $error("first period did not load the low dividend digit");

  property p_quotient_hold;
    @(posedge ref_clk) disable iff (rst)
      !active |=> $stable(quotient_digit);
  endproperty
  a_quotient_hold: assert property (p_quotient_hold) // [RL14]
    else $error("quotient digit changed outside a divide");

  property p_second_limit;
    @(posedge ref_clk) disable iff (rst)
      (second_iteration_period && trial.end_around_borrow[7:3] == 5'h1f)
      |=> (quotient_digit <= 3'h2);
  endproperty
  a_second_limit: assert property (p_second_limit) // [RL12]
    else $error("second period picked a rank above two");

  property p_top_gate;
    @(posedge ref_clk) disable iff (rst)
      (first_iteration_period && trial.end_around_borrow == all_flags)
      |=> (remainder[50:48] == 3'h0);
  endproperty
  a_top_gate: assert property (p_top_gate) // [RL5]
    else $error("top digit passed in the first period");

  // Main scenarios worth seeing in simulation.
  c_round_divide: cover property (@(posedge ref_clk) disable iff (rst)
    round_request_flag && last_iteration_period);
  c_rank_seven: cover property (@(posedge ref_clk) disable iff (rst)
    digit_valid && quotient_digit == 3'h7);
  c_restart: cover property (@(posedge ref_clk) disable iff (rst)
    (phase != PH_IDLE) && first_iteration_period);
  c_back_to_back: cover property (@(posedge ref_clk) disable iff (rst)
    last_iteration_period ##1 first_iteration_period);
  c_second_rank_two: cover property (@(posedge ref_clk) disable iff (rst)
    second_iteration_period && !trial.end_around_borrow[2]);

endmodule : radix8_divide_remainder_stage
`default_nettype wire

// file: verif/divide_far_side_model.sv
// Behavioural model of the divisor multiple network, trial network and sequencer forcing.
`timescale 1ns/1ps
`default_nettype none
module divide_far_side_model
  import divide_stage_pkg::*;
(
  input  wire logic          first_iteration_period,
  input  wire logic          second_iteration_period,
  input  wire logic [50:0]   remainder,
  input  wire logic [47:0]   divisor,
  input  wire logic          force_all,
  output var  multiples_t    multiples,
  output var  trial_result_t trial
);
  logic [47:0] mult;
  logic [47:0] low_mask;

  // Each rank compares the fed-back low 48 remainder bits with its multiple.
  // The borrow into group j is the borrow out of all digits below the digit that moves there.
  // The force_all knob is a deliberate fault that a scenario uses to pin every flag high.
  always_comb begin
    multiples = '0;
    trial     = '0;
    mult      = '0;
    low_mask  = '0;
    for (int r = 1; r <= 7; r++) begin
      mult               = divisor * 48'(r);
      multiples.value[r] = mult;
      trial.end_around_borrow[r] = (remainder[47:0] < mult)
        || first_iteration_period || force_all
        || (second_iteration_period && r >= 3);
      for (int j = 2; j <= 16; j++) begin
        low_mask = (48'h1 << (3 * (j - 1))) - 48'h1;
        trial.group_borrow[r][j] = (remainder[47:0] & low_mask) < (mult & low_mask);
      end
    end
  end
endmodule : divide_far_side_model
`default_nettype wire

// file: verif/radix8_divide_remainder_stage_test.sv
// Self-checking bench for the radix-8 remainder update stage.
`timescale 1ns/1ps
`default_nettype none
module radix8_divide_remainder_stage_test
  import divide_stage_pkg::*;
  ;
  logic          ref_clk                = 1'b0;
  logic          rst                    = 1'b1;
  logic          first_iteration_period = 1'b0;
  logic          round_request          = 1'b0;
  logic [47:0]   dividend               = 48'h0;
  logic [47:0]   divisor                = 48'h0;
  logic          force_all              = 1'b0;
  multiples_t    multiples;
  trial_result_t trial;
  logic [50:0]   remainder;
  logic [2:0]    quotient_digit;
  logic          digit_valid;
  logic          round_request_flag;
  logic          second_iteration_period;
  logic          last_iteration_period;
  logic          busy;
  int            err_count       = 0;
  int            samples_checked = 0;

  // Free-running 50 MHz clock.
  always #10 ref_clk = ~ref_clk;

  radix8_divide_remainder_stage uut (
    .ref_clk(ref_clk), .rst(rst), .first_iteration_period(first_iteration_period),
    .round_request(round_request), .dividend(dividend), .multiples(multiples),
    .trial(trial), .remainder(remainder), .quotient_digit(quotient_digit),
    .digit_valid(digit_valid), .round_request_flag(round_request_flag),
    .second_iteration_period(second_iteration_period),
    .last_iteration_period(last_iteration_period), .busy(busy));

  divide_far_side_model partner (
    .first_iteration_period(first_iteration_period),
    .second_iteration_period(second_iteration_period), .remainder(remainder),
    .divisor(divisor), .force_all(force_all), .multiples(multiples), .trial(trial));

  task automatic check_val(input string name, input logic [50:0] exp, input logic [50:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check_val

  task automatic check_bit(input string name, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask : check_bit

  task automatic check_idle();
    check_val("remainder", REM_RESET, remainder);
    check_val("quotient_digit", 51'(DIGIT_RESET), 51'(quotient_digit));
    check_bit("round_flag", FLAG_RESET, round_request_flag);
    check_bit("digit_valid", 1'b0, digit_valid);
    check_bit("busy", 1'b0, busy);
  endtask : check_idle

  // One whole divide, checked period by period against an independent reckoning.
  // With chain set, the next first period is launched in the cycle after period 17.
  task automatic run_divide(input logic [47:0] dv, input logic [47:0] ds, input logic rnd,
                            input logic fa, input logic started, input logic chain);
    logic [50:0] er;
    logic [2:0]  eq;
    logic [47:0] mult;
    int          top;
    er = '0;
    if (!started) begin
      @(posedge ref_clk);
      first_iteration_period <= 1'b1;
      dividend               <= dv;
      round_request          <= rnd;
      divisor                <= ds;
      force_all              <= fa;
    end
    for (int p = 1; p <= 17; p++) begin
      #1;
      check_bit("busy", 1'b1, busy);
      check_bit("second_period", p == 2, second_iteration_period);
      check_bit("last_period", p == 17, last_iteration_period);
      eq  = 3'h0;
      top = (p == 1 || fa) ? 0 : ((p == 2) ? 2 : 7);
      for (int k = 1; k <= top; k++) begin
        if (er[47:0] >= ds * 48'(k)) begin
          eq = 3'(k);
        end
      end
      mult = ds * 48'(eq);
      if (p == 1) begin
        er = {3'h0, dv};
      end else begin
        er = {er[47:0] - mult, rnd ? ((p % 2 == 0) ? ROUND_EVEN : ROUND_ODD) : LOW_ZERO};
      end
      @(posedge ref_clk);
      first_iteration_period <= (p == 17) && chain;
      if (p == 17 && chain) begin
        dividend      <= ~dv;
        round_request <= ~rnd;
      end
      #1;
      check_val("remainder", er, remainder);
      check_val("quotient_digit", 51'(eq), 51'(quotient_digit));
      check_bit("digit_valid", 1'b1, digit_valid);
      check_bit("round_flag", rnd, round_request_flag);
    end
    check_bit("busy_after", chain, busy);
    if (!chain) begin
      @(posedge ref_clk);
      #1;
      check_bit("digit_valid_idle", 1'b0, digit_valid);
      check_val("remainder_hold", er, remainder);
    end
  endtask : run_divide

  task automatic test_reset_values();
    repeat (2) @(posedge ref_clk);
    #1;
    check_idle();
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    check_idle();
    $display("test_reset_values done");
  endtask : test_reset_values

  task automatic test_plain_divide();
    run_divide(48'h5a5a_1234_0f0f, 48'h2468_ace0_1357, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test_plain_divide done");
  endtask : test_plain_divide

  task automatic test_round_divide();
    run_divide(48'hfedc_ba98_7654, 48'h1111_2222_3333, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test_round_divide done");
  endtask : test_round_divide

  // Back to back: the round divide reuses the inverted dividend of the first one.
  task automatic test_back_to_back();
    run_divide(48'h7fff_0000_1234, 48'h0000_3333_0001, 1'b0, 1'b0, 1'b0, 1'b1);
    run_divide(~48'h7fff_0000_1234, 48'h0000_3333_0001, 1'b1, 1'b0, 1'b1, 1'b0);
    $display("test_back_to_back done");
  endtask : test_back_to_back

  // All flags pinned high, so only the rank-zero path moves data, shifting the remainder up one octal digit each period.
  task automatic test_rank_zero_path();
    run_divide(48'he38e_38e3_8e39, 48'h0000_0000_0007, 1'b1, 1'b1, 1'b0, 1'b0);
    force_all <= 1'b0;
    $display("test_rank_zero_path done");
  endtask : test_rank_zero_path

  // A first period in mid-divide throws the old divide away and starts afresh.
  task automatic test_restart();
    @(posedge ref_clk);
    first_iteration_period <= 1'b1;
    dividend               <= 48'h0123_4567_89ab;
    round_request          <= 1'b0;
    divisor                <= 48'h0000_0000_0345;
    @(posedge ref_clk);
    first_iteration_period <= 1'b0;
    repeat (4) @(posedge ref_clk);
    first_iteration_period <= 1'b1;
    dividend               <= 48'h0ba9_8765_4321;
    round_request          <= 1'b1;
    run_divide(48'h0ba9_8765_4321, 48'h0000_0000_0345, 1'b1, 1'b0, 1'b1, 1'b0);
    $display("test_restart done");
  endtask : test_restart

  task automatic test_reset_mid();
    @(posedge ref_clk);
    first_iteration_period <= 1'b1;
    dividend               <= 48'h0f0f_0f0f_0f0f;
    round_request          <= 1'b1;
    @(posedge ref_clk);
    first_iteration_period <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b1;
    #1;
    check_idle();
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check_idle();
    $display("test_reset_mid done");
  endtask : test_reset_mid

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Main sequence.
  initial begin
    test_reset_values();
    test_plain_divide();
    test_round_divide();
    test_back_to_back();
    test_rank_zero_path();
    test_restart();
    test_reset_mid();
    complete_run();
  end

  // The tests need about 140 cycles; this limit leaves a wide margin before declaring a hang.
  initial begin
    #20000;
    err_count++;
    $display("ERROR watchdog expected finish seen hang");
    complete_run();
  end
endmodule : radix8_divide_remainder_stage_test
`default_nettype wire
